// >>> tb/qpes_chk.sv
// Port-level assertions for the quad program and erase sequencer
`timescale 1ns/1ps
`default_nettype none
module qpes_chk #(
  parameter [31:0] SE_CYCLES = 32'h1E,
  parameter [31:0] BE32_CYCLES = 32'h28,
  parameter [31:0] BE64_CYCLES = 32'h32
) (
  input wire CORE_CLK,
  input wire SYS_RST,
  input wire WEL_SET,
  input wire MEM_WR_READY,
  input wire BUSY,
  input wire WRITE_ENABLE_LATCH,
  input wire MEM_WR_VALID,
  input wire [31:0] MEM_WR_ADDR,
  input wire [7:0] MEM_WR_DATA,
  input wire MEM_ERASE_START,
  input wire [31:0] MEM_ERASE_ADDR,
  input wire [1:0] MEM_ERASE_SIZE,
  input wire [7:0] MEM_ERASE_FILL
);
  reg [31:0] cnt_r;
  reg er_r;
  reg [1:0] sz_r;
  wire [31:0] dur = (sz_r == 2'h0) ? SE_CYCLES : (sz_r == 2'h1) ? BE32_CYCLES : BE64_CYCLES;
  // Only erase lengths are judged; program length also depends on drain
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      cnt_r <= 32'h0;
      er_r <= 1'b0;
      sz_r <= 2'h0;
    end else begin
      cnt_r <= BUSY ? cnt_r + 32'h1 : 32'h0;
      er_r <= MEM_ERASE_START | (er_r & ~MEM_WR_VALID);
      if (MEM_ERASE_START) sz_r <= MEM_ERASE_SIZE;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  AST_ERASE_BUSY: assert property (MEM_ERASE_START |-> ##[0:1] BUSY) else $error("erase without busy");
  AST_ERASE_PULSE: assert property (MEM_ERASE_START |=> !MEM_ERASE_START) else $error("start too long");
  AST_ERASE_FILL: assert property (MEM_ERASE_START |-> MEM_ERASE_FILL == 8'hFF) else $error("bad fill");
  AST_SECT_ALIGN: assert property (MEM_ERASE_START && MEM_ERASE_SIZE == 2'h0 |->
    MEM_ERASE_ADDR[11:0] == 12'h000) else $error("sector misaligned");
  AST_B32_ALIGN: assert property (MEM_ERASE_START && MEM_ERASE_SIZE == 2'h1 |->
    MEM_ERASE_ADDR[14:0] == 15'h0000) else $error("32K misaligned");
  AST_B64_ALIGN: assert property (MEM_ERASE_START && MEM_ERASE_SIZE == 2'h2 |->
    MEM_ERASE_ADDR[15:0] == 16'h0000) else $error("64K misaligned");
  AST_NEEDS_LATCH: assert property ($rose(BUSY) |-> $past(WRITE_ENABLE_LATCH)) else $error("no latch");
  AST_LATCH_CLEAR: assert property ($fell(BUSY) && !$past(WEL_SET) |-> !WRITE_ENABLE_LATCH)
    else $error("latch kept");
  AST_ERASE_LENGTH: assert property ($fell(BUSY) && er_r |-> cnt_r + 32'h1 >= dur && cnt_r <= dur + 32'h3)
    else $error("erase length");
  AST_WR_IN_CYCLE: assert property (MEM_WR_VALID |-> BUSY) else $error("write while idle");
  AST_WR_HOLD: assert property (MEM_WR_VALID && !MEM_WR_READY |=> MEM_WR_VALID &&
    $stable(MEM_WR_ADDR) && $stable(MEM_WR_DATA)) else $error("write dropped");
endmodule // qpes_chk
`default_nettype wire

// >>> tb/qpes_host.sv
// Host serial controller model driving select, serial clock and lanes
`timescale 1ns/1ps
`default_nettype none
module qpes_host (
  output logic cs_n,
  output logic sck,
  output logic [3:0] io
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    io = 4'h0;
  end
  // Lanes change while the clock is low; unused lanes toggle so nothing looks held
  task automatic shift(input logic [31:0] v, input int n, input int w);
    int i;
    for (i = n; i > 0; i = i - w) begin
      io = (w == 4) ? v[i-1 -: 4] : {~io[3:1], v[i-1]};
      #100 sck = 1'b1;
      #100 sck = 1'b0;
    end
  endtask
  // Clock stands low outside frames
  task automatic frame(input logic [7:0] op, input logic [31:0] a, input int ab, input int aw,
    input int ow, input int nb, input logic [7:0] d0, input logic extra);
    int k;
    #37 cs_n = 1'b0;
    shift({24'h0, op}, 8, ow);
    shift(a, ab, aw);
    for (k = 0; k < nb; k++) shift({24'h0, d0 + k[7:0]}, 8, 4);
    if (extra) shift(32'h0, 1, 1);
    #100 cs_n = 1'b1;
    io = ~io;
  endtask
endmodule // qpes_host
`default_nettype wire

// >>> tb/quad_program_erase_sequencer_tb.sv
// Self-checking bench for the quad program and erase sequencer
`timescale 1ns/1ps
`default_nettype none
module quad_program_erase_sequencer_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic qe = 1'b1;
  logic four_lane_command_mode = 1'b0;
  logic fourb = 1'b0;
  logic [3:0] bp = 4'h0;
  logic cmp = 1'b0;
  logic tbs = 1'b0;
  logic wel_set = 1'b0;
  logic rdy = 1'b1;
  wire cs_n, sck, busy, write_enable_latch, vld, start;
  wire [3:0] io;
  wire [31:0] waddr, eaddr;
  wire [7:0] wdata, fill;
  wire [1:0] esize;
  int fails = 0;
  int num_checks = 0;
  int n_start = 0;
  int n_wr = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  qpes_host qpes_host_inst (.cs_n(cs_n), .sck(sck), .io(io));
  qpes_sequencer #(.PP_CYCLES(32'h14), .SE_CYCLES(32'h1E), .BE32_CYCLES(32'h28), .BE64_CYCLES(32'h32))
    qpes_sequencer_inst (.CORE_CLK(clk), .SYS_RST(rst), .SPI_CS_N(cs_n), .SPI_SCK(sck), .IO_LANE_IN(io),
    .QUAD_LANE_ENABLE_BIT(qe), .FOUR_LANE_COMMAND_MODE(four_lane_command_mode), .FOUR_BYTE_ADDR_MODE(fourb),
    .PROTECT_COMPLEMENT_BIT(cmp), .PROTECT_TOP_BOTTOM_SELECT(tbs), .BLOCK_PROTECT_BIT3(bp[3]),
    .BLOCK_PROTECT_BIT2(bp[2]), .BLOCK_PROTECT_BIT1(bp[1]), .BLOCK_PROTECT_BIT0(bp[0]), .WEL_SET(wel_set),
    .MEM_WR_READY(rdy), .BUSY(busy), .WRITE_ENABLE_LATCH(write_enable_latch), .MEM_WR_VALID(vld), .MEM_WR_ADDR(waddr),
    .MEM_WR_DATA(wdata), .MEM_ERASE_START(start), .MEM_ERASE_ADDR(eaddr), .MEM_ERASE_SIZE(esize),
    .MEM_ERASE_FILL(fill));
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (start === 1'b1) n_start <= n_start + 1;
    if (vld === 1'b1 && rdy === 1'b1) n_wr <= n_wr + 1;
    if (cyc == 20000) begin
      fails++;
      $display("unexpected at %0t: run hung", $time);
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bench inputs move one nanosecond after the edge; host pins move 13 ns after it
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic arm();
    wel_set = 1'b1;
    tick(1);
    wel_set = 1'b0;
  endtask
  task automatic wait_idle();
    int c;
    for (c = 0; c < 400 && busy !== 1'b0; c++) tick(1);
  endtask
  task automatic t_erase(input logic [7:0] op, input logic [31:0] a, input int ab, input int ow,
    input logic fb, input logic [1:0] sz, input logic [31:0] msk);
    int s;
    int c;
    s = n_start;
    fourb = fb;
    four_lane_command_mode = (ow == 4);
    arm();
    chk(write_enable_latch, 1'b1);
    qpes_host_inst.frame(op, a, ab, ow, ow, 0, 8'h00, 1'b0);
    for (c = 0; c < 60 && n_start == s; c++) tick(1);
    chk(busy, 1'b1);
    chk(eaddr, a & ~msk);
    chk(esize, sz);
    chk(fill, 8'hFF);
    wait_idle();
    chk(busy, 1'b0);
    chk(write_enable_latch, 1'b0);
    four_lane_command_mode = 1'b0;
    fourb = 1'b0;
  endtask
  task automatic t_refuse(input logic [7:0] op, input int ow, input int nb, input logic extra, input logic we);
    int s;
    int w;
    s = n_start;
    w = n_wr;
    if (we) arm();
    qpes_host_inst.frame(op, 32'h00010000, 24, ow, ow, nb, 8'h5A, extra);
    tick(40);
    chk(busy, 1'b0);
    chk(n_start - s, 32'h0);
    chk(n_wr - w, 32'h0);
  endtask
  task automatic t_prog(input logic [7:0] op, input logic [31:0] a, input int ab, input int aw, input int n);
    logic [7:0] m [256];
    logic h [256];
    int i;
    int c;
    int w;
    for (i = 0; i < 256; i++) h[i] = 1'b0;
    for (i = 0; i < n; i++) begin
      m[(a[7:0] + i) % 256] = 8'hC0 + i[7:0];
      h[(a[7:0] + i) % 256] = 1'b1;
    end
    w = n_wr;
    // Holding the array port off lets the buffer fill before it drains
    rdy = 1'b0;
    arm();
    qpes_host_inst.frame(op, a, ab, aw, 1, n, 8'hC0, 1'b0);
    tick(60);
    chk(busy, 1'b1);
    rdy = 1'b1;
    for (i = 0; i < 256; i++) begin
      if (h[i]) begin
        for (c = 0; c < 300 && vld !== 1'b1; c++) tick(1);
        chk(waddr, {a[31:8], i[7:0]});
        chk(wdata, m[i]);
        tick(1);
      end
    end
    wait_idle();
    chk(write_enable_latch, 1'b0);
    chk(n_wr - w, n);
  endtask
  task automatic t_busy();
    int s;
    int c;
    s = n_start;
    arm();
    qpes_host_inst.frame(8'h20, 32'h00002000, 24, 1, 1, 0, 8'h00, 1'b0);
    for (c = 0; c < 60 && n_start == s; c++) tick(1);
    chk(busy, 1'b1);
    // Select falls while busy; the latch is set again before the opcode ends
    fork
      qpes_host_inst.frame(8'h20, 32'h00003000, 24, 1, 1, 0, 8'h00, 1'b0);
      begin
        tick(50);
        arm();
      end
    join
    tick(40);
    chk(n_start - s, 32'h1);
    chk(busy, 1'b0);
    chk(write_enable_latch, 1'b1);
  endtask
  initial begin
    tick(4);
    rst = 1'b0;
    tick(4);
    t_erase(8'h20, 32'h00123456, 24, 1, 1'b0, 2'h0, 32'h00000FFF);
    t_erase(8'h21, 32'h01ABCDEF, 32, 1, 1'b0, 2'h0, 32'h00000FFF);
    t_erase(8'h52, 32'h00FF9876, 32, 1, 1'b1, 2'h1, 32'h00007FFF);
    t_erase(8'hD8, 32'h00345678, 24, 4, 1'b0, 2'h2, 32'h0000FFFF);
    t_refuse(8'h20, 1, 0, 1'b0, 1'b0);
    t_refuse(8'h32, 1, 1, 1'b0, 1'b0);
    qe = 1'b0;
    t_refuse(8'h32, 1, 1, 1'b0, 1'b1);
    qe = 1'b1;
    four_lane_command_mode = 1'b1;
    t_refuse(8'h32, 4, 1, 1'b0, 1'b1);
    four_lane_command_mode = 1'b0;
    t_refuse(8'h20, 1, 0, 1'b1, 1'b1);
    bp = 4'hA;
    t_refuse(8'h20, 1, 0, 1'b0, 1'b1);
    cmp = 1'b1;
    t_erase(8'h20, 32'h00123456, 24, 1, 1'b0, 2'h0, 32'h00000FFF);
    cmp = 1'b0;
    bp = 4'h2;
    tbs = 1'b1;
    t_refuse(8'h20, 1, 0, 1'b0, 1'b1);
    tbs = 1'b0;
    bp = 4'h0;
    t_busy();
    t_prog(8'h32, 32'h00042AFA, 24, 1, 12);
    t_prog(8'h33, 32'h00051200, 24, 4, 2);
    t_prog(8'h34, 32'h01067710, 32, 1, 3);
    final_report();
  end
endmodule // quad_program_erase_sequencer_tb
bind qpes_sequencer qpes_chk #(.SE_CYCLES(SE_CYCLES), .BE32_CYCLES(BE32_CYCLES), .BE64_CYCLES(BE64_CYCLES))
  qpes_chk_inst (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .WEL_SET(WEL_SET), .MEM_WR_READY(MEM_WR_READY),
  .BUSY(BUSY), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .MEM_WR_VALID(MEM_WR_VALID),
  .MEM_WR_ADDR(MEM_WR_ADDR), .MEM_WR_DATA(MEM_WR_DATA), .MEM_ERASE_START(MEM_ERASE_START),
  .MEM_ERASE_ADDR(MEM_ERASE_ADDR), .MEM_ERASE_SIZE(MEM_ERASE_SIZE), .MEM_ERASE_FILL(MEM_ERASE_FILL));
`default_nettype wire

// >>> verilog/qpes_fifo.v
// Word FIFO with registered head between page buffer and array write port
`timescale 1ns/1ps
`default_nettype none
module qpes_fifo #(
  parameter WIDTH = 40,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst,
  input wire s_valid,
  output wire s_ready,
  input wire [WIDTH-1:0] s_data,
  output reg m_valid,
  input wire m_ready,
  output reg [WIDTH-1:0] m_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_r;
  reg [AW-1:0] rd_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;
  // Head register keeps the outgoing word on a flip-flop
  assign s_ready = (cnt_r != DEPTH[AW:0]);
  assign push = s_valid & s_ready;
  assign pop = (cnt_r != {(AW+1){1'b0}}) & (~m_valid | m_ready);
  always @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= s_data;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      wr_r <= {AW{1'b0}};
      rd_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      m_valid <= 1'b0;
      m_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
        m_data <= mem[rd_r];
        m_valid <= 1'b1;
      end else if (m_ready) begin
        m_valid <= 1'b0;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // qpes_fifo
`default_nettype wire

// >>> verilog/qpes_regs.vh
// Constants shared by the quad program / erase sequencer
`ifndef QPES_REGS_VH
`define QPES_REGS_VH
`define QPES_OP_QPP 8'h32
`define QPES_OP_QPP_QA 8'h33
`define QPES_OP_QPP_4B 8'h34
`define QPES_OP_SE 8'h20
`define QPES_OP_SE_4B 8'h21
`define QPES_OP_BE32 8'h52
`define QPES_OP_BE64 8'hD8
`define QPES_OPC_BITS 6'h08
`define QPES_ABITS_3B 6'h18
`define QPES_ABITS_4B 6'h20
`define QPES_STEP_1 6'h01
`define QPES_STEP_4 6'h04
`define QPES_SZ_SECT 2'h0
`define QPES_SZ_B32 2'h1
`define QPES_SZ_B64 2'h2
`define QPES_MASK_SECT 32'h00000FFF
`define QPES_MASK_B32 32'h00007FFF
`define QPES_MASK_B64 32'h0000FFFF
`define QPES_PAGE_LAST 8'hFF
`define QPES_ERASED_BYTE 8'hFF
`define QPES_BP_ALL 4'hA
`define QPES_NUM_BLKS 10'h200
`define QPES_BLK_MSB 24
`define QPES_BLK_LSB 16
`define QPES_CLK_MHZ 40
`define QPES_T_PP_US 100
`define QPES_T_SE_US 1000
`define QPES_T_BE32_US 2000
`define QPES_T_BE64_US 4000
`endif

// >>> verilog/qpes_sequencer.v
// Quad page program and sector/block erase sequencer behind the serial pins
// Behaviour
// R1: 32h takes address plus up to 256 bytes
// R2: Quad program needs quad lane enable set
// R3: Quad program refused while write latch clear
// R4: Host holds select low whole transfer
// R5: Quad program otherwise matches single-lane program
// R6: 33h takes address and data on four lanes
// R7: 34h always takes 32-bit address
// R8: Four-byte mode makes addresses 32-bit
// R9: 20h erases addressed 4K sector to FFh
// R10: 21h sector erase with 32-bit address
// R11: 52h erases addressed 32K block
// R12: D8h erases addressed 64K block
// R13: Erases refused while write latch clear
// R14: Host sends address right after opcode
// R15: Select rise off boundary discards command
// R16: Erase runs self-timed with busy held
// R17: Busy stays readable during the cycle
// R18: Finished erase clears write latch
// R19: Protected target is never erased
// R20: Quad program only in single-lane opcode mode
// R21: Page address wraps within 256 bytes
// R22: Program self-timed, clears latch, skips protected
// R23: Refused command leaves array and busy alone
// R24: Each erase size has own duration
`timescale 1ns/1ps
`default_nettype none
`include "qpes_regs.vh"
module qpes_sequencer #(
  parameter [31:0] PP_CYCLES = `QPES_T_PP_US * `QPES_CLK_MHZ,
  parameter [31:0] SE_CYCLES = `QPES_T_SE_US * `QPES_CLK_MHZ,
  parameter [31:0] BE32_CYCLES = `QPES_T_BE32_US * `QPES_CLK_MHZ,
  parameter [31:0] BE64_CYCLES = `QPES_T_BE64_US * `QPES_CLK_MHZ,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire CORE_CLK,
  input wire SYS_RST,
  input wire SPI_CS_N,
  input wire SPI_SCK,
  input wire [3:0] IO_LANE_IN,
  input wire QUAD_LANE_ENABLE_BIT,
  input wire FOUR_LANE_COMMAND_MODE,
  input wire FOUR_BYTE_ADDR_MODE,
  input wire PROTECT_COMPLEMENT_BIT,
  input wire PROTECT_TOP_BOTTOM_SELECT,
  input wire BLOCK_PROTECT_BIT3,
  input wire BLOCK_PROTECT_BIT2,
  input wire BLOCK_PROTECT_BIT1,
  input wire BLOCK_PROTECT_BIT0,
  input wire WEL_SET,
  input wire MEM_WR_READY,
  output reg BUSY,
  output reg WRITE_ENABLE_LATCH,
  output wire MEM_WR_VALID,
  output wire [31:0] MEM_WR_ADDR,
  output wire [7:0] MEM_WR_DATA,
  output reg MEM_ERASE_START,
  output reg [31:0] MEM_ERASE_ADDR,
  output reg [1:0] MEM_ERASE_SIZE,
  output reg [7:0] MEM_ERASE_FILL
);
  localparam [2:0] F_IDLE = 3'h0;
  localparam [2:0] F_OPC = 3'h1;
  localparam [2:0] F_ADDR = 3'h2;
  localparam [2:0] F_DATA = 3'h3;
  localparam [2:0] F_END = 3'h4;
  localparam [2:0] F_IGN = 3'h5;
  localparam [1:0] X_IDLE = 2'h0;
  localparam [1:0] X_DRAIN = 2'h1;
  localparam [1:0] X_TIME = 2'h2;

  // Pin synchronisers; stage 0 feeds only stage 1
  reg [2:0] cs_sy_r;
  reg [2:0] sck_sy_r;
  reg [3:0] io_a_r;
  reg [3:0] io_b_r;
  reg [3:0] io_c_r;
  reg cs_f_r;
  reg cs_d_r;
  reg sck_f_r;
  reg sck_d_r;
  reg [3:0] io_f_r;
  wire [3:0] io_dis;
  wire cs_rise;
  wire cs_fall;
  wire sck_rise;

  assign io_dis = io_b_r ^ io_c_r;
  assign cs_rise = cs_f_r & ~cs_d_r;
  assign cs_fall = ~cs_f_r & cs_d_r;
  assign sck_rise = sck_f_r & ~sck_d_r & ~cs_f_r;

  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      cs_sy_r <= 3'h7;
      sck_sy_r <= 3'h0;
      io_a_r <= 4'h0;
      io_b_r <= 4'h0;
      io_c_r <= 4'h0;
      cs_f_r <= 1'b1;
      cs_d_r <= 1'b1;
      sck_f_r <= 1'b0;
      sck_d_r <= 1'b0;
      io_f_r <= 4'h0;
    end else begin
      cs_sy_r <= {cs_sy_r[1:0], SPI_CS_N};
      sck_sy_r <= {sck_sy_r[1:0], SPI_SCK};
      io_a_r <= IO_LANE_IN;
      io_b_r <= io_a_r;
      io_c_r <= io_b_r;
      // A change counts only once stages one and two agree
      if (cs_sy_r[1] == cs_sy_r[2]) begin
        cs_f_r <= cs_sy_r[2];
      end
      if (sck_sy_r[1] == sck_sy_r[2]) begin
        sck_f_r <= sck_sy_r[2];
      end
      io_f_r <= (~io_dis & io_c_r) | (io_dis & io_f_r);
      cs_d_r <= cs_f_r;
      sck_d_r <= sck_f_r;
    end
  end

  // Frame decoder state
  reg [2:0] fst_r;
  reg [31:0] sh_r;
  reg [5:0] bcnt_r;
  reg lanes4_r;
  reg [5:0] abits_r;
  reg is_prog_r;
  reg [1:0] esize_r;
  reg [31:0] addr_r;
  reg [7:0] boff_r;
  reg nib_r;
  reg [3:0] half_r;
  reg got_r;
  reg [7:0] pbuf [0:255];
  reg [255:0] loaded_r;
  wire [31:0] sh_nxt;
  wire [5:0] bcnt_nxt;
  wire [7:0] opc;
  wire is_quad;
  wire is_era;
  wire ok_q;
  wire ok_e;
  wire addr32;

  assign sh_nxt = lanes4_r ? {sh_r[27:0], io_f_r} : {sh_r[30:0], io_f_r[0]};
  assign bcnt_nxt = bcnt_r + (lanes4_r ? `QPES_STEP_4 : `QPES_STEP_1);
  assign opc = sh_nxt[7:0];
  assign is_quad = (opc == `QPES_OP_QPP) | (opc == `QPES_OP_QPP_QA) | (opc == `QPES_OP_QPP_4B);
  assign is_era = (opc == `QPES_OP_SE) | (opc == `QPES_OP_SE_4B) |
                  (opc == `QPES_OP_BE32) | (opc == `QPES_OP_BE64);
  assign ok_q = is_quad & ~FOUR_LANE_COMMAND_MODE & QUAD_LANE_ENABLE_BIT & WRITE_ENABLE_LATCH; // R2 R3 R20
  assign ok_e = is_era & WRITE_ENABLE_LATCH; // R13
  assign addr32 = (opc == `QPES_OP_QPP_4B) | (opc == `QPES_OP_SE_4B) | FOUR_BYTE_ADDR_MODE; // R7 R8 R10

  // Block protection: BP 1 to 9 picks 2^(BP-1) 64K blocks from top or bottom; Ah and up picks all 512
  wire [3:0] bp;
  wire [9:0] pcnt;
  wire [9:0] blk;
  wire in_reg;
  wire prot;
  assign bp = {BLOCK_PROTECT_BIT3, BLOCK_PROTECT_BIT2, BLOCK_PROTECT_BIT1, BLOCK_PROTECT_BIT0};
  assign pcnt = (bp == 4'h0) ? 10'h000 :
                (bp >= `QPES_BP_ALL) ? `QPES_NUM_BLKS : (10'h001 << (bp - 4'h1));
  assign blk = {1'b0, addr_r[`QPES_BLK_MSB:`QPES_BLK_LSB]};
  assign in_reg = PROTECT_TOP_BOTTOM_SELECT ? (blk < pcnt) : (blk >= (`QPES_NUM_BLKS - pcnt));
  assign prot = in_reg ^ PROTECT_COMPLEMENT_BIT;

  // Launch only on a clean boundary and an unprotected target
  wire launch_prog;
  wire launch_erase;
  assign launch_prog = cs_rise & (fst_r == F_DATA) & got_r & ~nib_r & ~prot; // R15 R22 R23
  assign launch_erase = cs_rise & (fst_r == F_END) & ~prot; // R15 R19 R23

  always @(posedge CORE_CLK) begin
    if (fst_r == F_DATA && sck_rise && nib_r) begin
      pbuf[addr_r[7:0] + boff_r] <= {half_r, io_f_r}; // R1 R21
    end
  end

  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      fst_r <= F_IDLE;
      sh_r <= 32'h00000000;
      bcnt_r <= 6'h00;
      lanes4_r <= 1'b0;
      abits_r <= `QPES_ABITS_3B;
      is_prog_r <= 1'b0;
      esize_r <= `QPES_SZ_SECT;
      addr_r <= 32'h00000000;
      boff_r <= 8'h00;
      nib_r <= 1'b0;
      half_r <= 4'h0;
      got_r <= 1'b0;
      loaded_r <= {256{1'b0}};
    end else if (cs_rise) begin
      fst_r <= F_IDLE;
    end else if (cs_fall) begin
      // While a cycle runs only status reads elsewhere are served
      fst_r <= BUSY ? F_IGN : F_OPC; // R17 R23
      sh_r <= 32'h00000000;
      bcnt_r <= 6'h00;
      lanes4_r <= FOUR_LANE_COMMAND_MODE;
      boff_r <= 8'h00;
      nib_r <= 1'b0;
      got_r <= 1'b0;
      if (!BUSY) begin
        loaded_r <= {256{1'b0}};
      end
    end else if (sck_rise) begin
      case (fst_r)
        F_OPC: begin
          sh_r <= sh_nxt;
          bcnt_r <= bcnt_nxt;
          if (bcnt_nxt == `QPES_OPC_BITS) begin
            bcnt_r <= 6'h00;
            sh_r <= 32'h00000000;
            if (ok_q | ok_e) begin
              fst_r <= F_ADDR; // R14
              abits_r <= addr32 ? `QPES_ABITS_4B : `QPES_ABITS_3B;
              lanes4_r <= (opc == `QPES_OP_QPP_QA) | (is_era & FOUR_LANE_COMMAND_MODE); // R6
              is_prog_r <= is_quad;
              esize_r <= ((opc == `QPES_OP_SE) | (opc == `QPES_OP_SE_4B)) ? `QPES_SZ_SECT :
                         (opc == `QPES_OP_BE32) ? `QPES_SZ_B32 : `QPES_SZ_B64;
            end else begin
              fst_r <= F_IGN;
            end
          end
        end
        F_ADDR: begin
          sh_r <= sh_nxt;
          bcnt_r <= bcnt_nxt;
          if (bcnt_nxt == abits_r) begin
            addr_r <= (abits_r == `QPES_ABITS_3B) ? {8'h00, sh_nxt[23:0]} : sh_nxt; // R8
            fst_r <= is_prog_r ? F_DATA : F_END;
            lanes4_r <= 1'b1;
          end
        end
        F_DATA: begin
          // Data always arrives as nibbles, high half first
          nib_r <= ~nib_r;
          if (!nib_r) begin
            half_r <= io_f_r; // R1
          end else begin
            loaded_r[addr_r[7:0] + boff_r] <= 1'b1;
            boff_r <= boff_r + 8'h01; // R21
            got_r <= 1'b1;
          end
        end
        F_END: begin
          fst_r <= F_IGN; // R15
        end
        default: begin
          fst_r <= fst_r;
        end
      endcase
    end
  end

  // Self-timed execution
  reg [1:0] xst_r;
  reg [31:0] tmr_r;
  reg [7:0] idx_r;
  reg [23:0] page_r;
  // A word pushed into an empty buffer shows valid two cycles later
  reg pushed_r;
  wire fifo_in_ready;
  wire push_v;
  wire step;
  wire [39:0] fifo_out;
  wire [31:0] emask;
  wire [31:0] etime;

  assign push_v = (xst_r == X_DRAIN) & loaded_r[idx_r];
  assign step = (xst_r == X_DRAIN) & (~loaded_r[idx_r] | fifo_in_ready);
  assign emask = (esize_r == `QPES_SZ_SECT) ? `QPES_MASK_SECT :
                 (esize_r == `QPES_SZ_B32) ? `QPES_MASK_B32 : `QPES_MASK_B64;
  assign etime = (esize_r == `QPES_SZ_SECT) ? SE_CYCLES :
                 (esize_r == `QPES_SZ_B32) ? BE32_CYCLES : BE64_CYCLES; // R24
  assign MEM_WR_ADDR = fifo_out[39:8];
  assign MEM_WR_DATA = fifo_out[7:0];

  // Back-pressure from the array port stalls the page walk
  qpes_fifo #(
    .WIDTH(40),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .s_valid(push_v),
    .s_ready(fifo_in_ready),
    .s_data({page_r, idx_r, pbuf[idx_r]}),
    .m_valid(MEM_WR_VALID),
    .m_ready(MEM_WR_READY),
    .m_data(fifo_out)
  );

  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      xst_r <= X_IDLE;
      tmr_r <= 32'h00000000;
      idx_r <= 8'h00;
      page_r <= 24'h000000;
      pushed_r <= 1'b0;
      BUSY <= 1'b0;
      WRITE_ENABLE_LATCH <= 1'b0;
      MEM_ERASE_START <= 1'b0;
      MEM_ERASE_ADDR <= 32'h00000000;
      MEM_ERASE_SIZE <= `QPES_SZ_SECT;
      MEM_ERASE_FILL <= `QPES_ERASED_BYTE;
    end else begin
      MEM_ERASE_START <= 1'b0;
      pushed_r <= push_v & fifo_in_ready;
      if (tmr_r != 32'h00000000) begin
        tmr_r <= tmr_r - 32'h00000001;
      end
      case (xst_r)
        X_IDLE: begin
          if (launch_prog) begin
            BUSY <= 1'b1; // R5 R22
            xst_r <= X_DRAIN;
            idx_r <= 8'h00;
            page_r <= addr_r[31:8];
            tmr_r <= PP_CYCLES;
          end else if (launch_erase) begin
            BUSY <= 1'b1; // R16
            xst_r <= X_TIME;
            tmr_r <= etime; // R24
            MEM_ERASE_START <= 1'b1; // R9 R11 R12
            MEM_ERASE_ADDR <= addr_r & ~emask;
            MEM_ERASE_SIZE <= esize_r;
            MEM_ERASE_FILL <= `QPES_ERASED_BYTE;
          end
        end
        X_DRAIN: begin
          if (step) begin
            idx_r <= idx_r + 8'h01;
            if (idx_r == `QPES_PAGE_LAST) begin
              xst_r <= X_TIME;
            end
          end
        end
        X_TIME: begin
          if (tmr_r == 32'h00000000 && !MEM_WR_VALID && !pushed_r) begin
            BUSY <= 1'b0; // R16 R22
            xst_r <= X_IDLE;
          end
        end
        default: begin
          xst_r <= X_IDLE;
        end
      endcase
      // A set arriving with the end of a cycle wins over the clear
      if (WEL_SET) begin
        WRITE_ENABLE_LATCH <= 1'b1;
      end else if (xst_r == X_TIME && tmr_r == 32'h00000000 && !MEM_WR_VALID && !pushed_r) begin
        WRITE_ENABLE_LATCH <= 1'b0; // R18 R22
      end
    end
  end
endmodule // qpes_sequencer
`default_nettype wire
